// ==== verilog/remote_point_input_mapper.sv ====
/*
 * Point mapper: originator filter, remote and direct inputs with
 * defaults, transmit points with resend, and latch resets.
 * Assumes one-cycle message and direct strobes on ref_clk
 * and a plain strobe register master.
 */
// Added by the designer: strobed register access and the address map.
`default_nettype none

`include "rpim_cfg.svh"

module remote_point_input_mapper
    import rpim_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = `RPIM_SEC_MS * `RPIM_NS_PER_MS / `RPIM_CLK_PERIOD_NS
)
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        rx_valid,
    input  wire logic        rx_goose,
    input  wire logic [31:0] rx_orig_id,
    input  wire logic [11:0] rx_vlan,
    input  wire logic [15:0] rx_appid,
    input  wire logic [15:0] rx_ttl_s,
    input  wire logic [63:0] rx_dna,
    input  wire logic [63:0] rx_userst,
    input  wire logic        dir_valid,
    input  wire logic [3:0]  dir_dev_id,
    input  wire logic [31:0] dir_bits,
    input  wire logic [15:0] dir_dev_online,
    input  wire logic [63:0] int_sig,
    input  wire logic        test_mode,
    input  wire logic        conf_rev,
    output logic             tx_valid,
    output logic             tx_goose,
    output logic      [63:0] tx_dna,
    output logic      [63:0] tx_userst,
    output logic      [31:0] dir_out,
    output logic      [31:0] remote_in,
    output logic      [31:0] direct_in,
    input  wire logic        front_button_req,
    input  wire logic        link_reset_req,
    input  wire logic [7:0]  latch_cond,
    output logic      [7:0]  latched_flags,
    output logic             any_source_reset_pulse,
    output logic             reset_from_front_button,
    output logic             reset_from_link,
    output logic             reset_from_logic_signal,
    output logic             irq
);

    localparam int NO = `RPIM_N_ORIG;
    localparam int NP = `RPIM_N_POINT;

    // Configuration storage
    logic [31:0]        orig_id_mem  [0:NO-1];
    logic [31:0]        orig_mat_mem [0:NO-1];
    logic [13:0]        remin_cfg    [0:NP-1];
    logic [13:0]        dirin_cfg    [0:NP-1];
    logic [5:0]         dna_sel      [0:NP-1];
    logic [5:0]         user_sel     [0:NP-1];
    logic [5:0]         dout_sel     [0:NP-1];
    logic [31:0]        ctrl_r;
    logic [`RPIM_ST_W-1:0] status_r;
    logic [`RPIM_ST_W-1:0] mask_r;
    logic [31:0]        rdata_r;
    logic [15:0]        rst_count_r;

    // Runtime state
    logic [NO-1:0]      online_r;
    logic [15:0]        ttl_r        [0:NO-1];
    logic [NP-1:0]      rin_val_r;
    logic [NP-1:0]      rin_known_r;
    logic [NP-1:0]      din_val_r;
    logic [NP-1:0]      din_known_r;
    logic [NP-1:0]      remote_in_r;
    logic [NP-1:0]      direct_in_r;
    logic [31:0]        sec_cnt_r;
    logic [5:0]         elapsed_r;
    logic               powerup_r;
    logic [95:0]        snap_r;
    logic               tx_valid_r;
    logic [63:0]        tx_dna_r;
    logic [63:0]        tx_user_r;
    logic [31:0]        dir_out_r;
    logic [`RPIM_N_LATCH-1:0] latched_r;
    logic               logic_sig_d_r;
    logic               rst_btn_r;
    logic               rst_link_r;
    logic               rst_logic_r;

    // Control field views
    wire fmt_t        fmt      = fmt_t'(ctrl_r[`RPIM_CTRL_FMT_LSB +: 2]);
    wire logic [5:0]  interval = ctrl_r[`RPIM_CTRL_INT_LSB +: 6];
    wire logic [5:0]  rst_sel  = ctrl_r[`RPIM_CTRL_RSEL_LSB +: 6];

    // Register address decode
    wire logic [4:0] ent      = reg_addr[4:0];
    wire logic       wr_ctrl  = reg_wr && (reg_addr == `RPIM_A_CTRL);
    wire logic       wr_mask  = reg_wr && (reg_addr == `RPIM_A_MASK);
    wire logic       rd_stat  = reg_rd && (reg_addr == `RPIM_A_STATUS);
    wire logic       hit_oid  = reg_addr[7:4] == `RPIM_PFX_ORIG_ID;
    wire logic       hit_omat = reg_addr[7:4] == `RPIM_PFX_ORIG_MATCH;
    wire logic       hit_rin  = reg_addr[7:5] == `RPIM_PFX_REMIN;
    wire logic       hit_din  = reg_addr[7:5] == `RPIM_PFX_DIRIN;
    wire logic       hit_dna  = reg_addr[7:5] == `RPIM_PFX_DNA_SEL;
    wire logic       hit_usr  = reg_addr[7:5] == `RPIM_PFX_USER_SEL;
    wire logic       hit_dout = reg_addr[7:5] == `RPIM_PFX_DOUT_SEL;

    // One-second tick for both timers
    wire logic sec_tick = (sec_cnt_r == SEC_CYCLES - 1);

    // Originator matching
    wire logic fmt_ok = (fmt != FMT_NONE) && (rx_goose == (fmt == FMT_GOOSE));
    logic [NO-1:0] orig_hit;
    logic [NO-1:0] orig_expire;
    genvar go;
    generate
        for (go = 0; go < NO; go++)
        begin : g_orig
            wire logic [31:0] m = orig_mat_mem[go];
            wire logic id_eq   = m[`RPIM_OM_VALID_BIT] && (rx_orig_id == orig_id_mem[go]);
            wire logic tag_eq  = (rx_vlan == m[`RPIM_OM_VLAN_LSB +: 12])
                               && (rx_appid == m[`RPIM_OM_APPID_LSB +: 16]);
            assign orig_hit[go]    = rx_valid && fmt_ok && id_eq && (!rx_goose || tag_eq);
            assign orig_expire[go] = sec_tick && online_r[go] && (ttl_r[go] <= 16'h0001);
        end
    endgenerate

    // Lowest matching entry wins
    function automatic logic [3:0] first_hit(input logic [NO-1:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = NO - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    wire logic       accept  = |orig_hit;
    wire logic [3:0] acc_idx = first_hit(orig_hit);

    // Remote and direct inputs with defaults
    logic [NP-1:0] rin_now;
    logic [NP-1:0] rin_upd;
    logic [NP-1:0] din_now;
    logic [NP-1:0] din_upd;
    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++)
        begin : g_pt
            wire logic [3:0] r_dev = remin_cfg[gp][`RPIM_CFG_DEV_LSB +: 4];
            wire logic [5:0] r_sel = remin_cfg[gp][`RPIM_CFG_SEL_LSB +: 6];
            wire def_t       r_def = def_t'(remin_cfg[gp][`RPIM_CFG_DEF_LSB +: 2]);
            wire logic [4:0] r_pr  = r_sel[4:0];
            // Pair state is the upper bit of the pair
            wire logic r_bit = r_sel[5] ? rx_userst[{r_pr, 1'b1}] : rx_dna[{r_pr, 1'b1}];
            wire logic r_ok  = online_r[r_dev] && rin_known_r[gp];
            assign rin_upd[gp] = accept && (acc_idx == r_dev);
            assign rin_now[gp] = r_ok ? rin_val_r[gp] :
                                 (r_def == DEF_ON) ? 1'b1 :
                                 (r_def == DEF_OFF) ? 1'b0 :
                                 (rin_known_r[gp] ? rin_val_r[gp] : r_def == DEF_LATEST_ON);

            wire logic [3:0] d_dev = dirin_cfg[gp][`RPIM_CFG_DEV_LSB +: 4];
            wire logic [4:0] d_sel = dirin_cfg[gp][`RPIM_CFG_SEL_LSB +: 5];
            wire def_t       d_def = def_t'(dirin_cfg[gp][`RPIM_CFG_DEF_LSB +: 2]);
            wire logic d_ok  = dir_dev_online[d_dev] && din_known_r[gp];
            assign din_upd[gp] = dir_valid && dir_dev_online[dir_dev_id] && (dir_dev_id == d_dev);
            assign din_now[gp] = d_ok ? din_val_r[gp] :
                                 (d_def == DEF_ON) ? 1'b1 :
                                 (d_def == DEF_OFF) ? 1'b0 :
                                 (din_known_r[gp] ? din_val_r[gp] : d_def == DEF_LATEST_ON);

            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                begin
                    rin_val_r[gp]   <= 1'b0;
                    rin_known_r[gp] <= 1'b0;
                    din_val_r[gp]   <= 1'b0;
                    din_known_r[gp] <= 1'b0;
                end
                else
                begin
                    if (rin_upd[gp])
                    begin
                        rin_val_r[gp]   <= r_bit;
                        rin_known_r[gp] <= 1'b1;
                    end
                    else if (reg_wr && hit_rin && ent == 5'(gp))
                    begin
                        rin_known_r[gp] <= 1'b0;
                    end
                    if (din_upd[gp])
                    begin
                        din_val_r[gp]   <= dir_bits[d_sel];
                        din_known_r[gp] <= 1'b1;
                    end
                    else if (reg_wr && hit_din && ent == 5'(gp))
                    begin
                        din_known_r[gp] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Transmit point selection
    logic [NP-1:0] pt_dna;
    logic [NP-1:0] pt_user;
    logic [NP-1:0] pt_dout;
    logic [63:0]   dna_pairs;
    logic [63:0]   user_pairs;
    genvar gt;
    generate
        for (gt = 0; gt < NP; gt++)
        begin : g_tx
            if (gt == `RPIM_DNA_TEST)
            begin : g_test
                assign pt_dna[gt] = test_mode;
            end
            else if (gt == `RPIM_DNA_CONFREV)
            begin : g_rev
                assign pt_dna[gt] = conf_rev;
            end
            else
            begin : g_user
                assign pt_dna[gt] = int_sig[dna_sel[gt]];
            end
            assign pt_user[gt] = int_sig[user_sel[gt]];
            assign pt_dout[gt] = int_sig[dout_sel[gt]];
            assign dna_pairs[2*gt +: 2]  = {pt_dna[gt], ~pt_dna[gt]};
            assign user_pairs[2*gt +: 2] = {pt_user[gt], ~pt_user[gt]};
        end
    endgenerate

    // Send on startup, change or interval
    wire logic [95:0] pt_all   = {pt_dout, pt_user, pt_dna};
    wire logic [5:0]  int_eff  = (interval < `RPIM_INTERVAL_MIN) ? `RPIM_INTERVAL_MIN : interval;
    wire logic        due      = sec_tick && (6'(elapsed_r + 6'h01) >= int_eff);
    wire logic        changed  = pt_all[63:0] != snap_r[63:0];
    wire logic        send     = (fmt != FMT_NONE) && (powerup_r || changed || due);

    // Reset command sources
    wire logic logic_sig  = int_sig[rst_sel];
    wire logic logic_rise = logic_sig && !logic_sig_d_r;
    wire logic any_rst    = front_button_req || link_reset_req || logic_rise;

    // Status events; set beats clear-on-read
    logic [`RPIM_ST_W-1:0] events;
    assign events[`RPIM_ST_RX_ACCEPT] = accept;
    assign events[`RPIM_ST_ORIG_LOST] = |orig_expire;
    assign events[`RPIM_ST_RESET]     = any_rst;
    assign events[`RPIM_ST_TX_SENT]   = send;
    wire logic [`RPIM_ST_W-1:0] status_nxt = (rd_stat ? '0 : status_r) | events;

    // Configuration writes
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ctrl_r <= 32'(FMT_GSSE) | (32'(`RPIM_INTERVAL_RST) << `RPIM_CTRL_INT_LSB);
            mask_r <= '0;
            for (int i = 0; i < NO; i++)
            begin
                orig_id_mem[i]  <= 32'h0;
                orig_mat_mem[i] <= 32'h0;
            end
            for (int i = 0; i < NP; i++)
            begin
                remin_cfg[i] <= 14'h0;
                dirin_cfg[i] <= 14'h0;
                dna_sel[i]   <= 6'h0;
                user_sel[i]  <= 6'h0;
                dout_sel[i]  <= 6'h0;
            end
        end
        else if (reg_wr)
        begin
            if (wr_ctrl)  ctrl_r <= reg_wdata;
            if (wr_mask)  mask_r <= reg_wdata[`RPIM_ST_W-1:0];
            if (hit_oid)  orig_id_mem[ent[3:0]]  <= reg_wdata;
            if (hit_omat) orig_mat_mem[ent[3:0]] <= reg_wdata;
            if (hit_rin)  remin_cfg[ent] <= reg_wdata[13:0];
            if (hit_din)  dirin_cfg[ent] <= reg_wdata[13:0];
            if (hit_dna)  dna_sel[ent]   <= reg_wdata[5:0];
            if (hit_usr)  user_sel[ent]  <= reg_wdata[5:0];
            if (hit_dout) dout_sel[ent]  <= reg_wdata[5:0];
        end
    end

    // Originator liveness and TTL
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            online_r <= '0;
            for (int i = 0; i < NO; i++)
            begin
                ttl_r[i] <= 16'h0;
            end
        end
        else
        begin
            for (int i = 0; i < NO; i++)
            begin
                if (accept && acc_idx == 4'(i))
                begin
                    online_r[i] <= 1'b1;
                    ttl_r[i]    <= rx_ttl_s;
                end
                else if (orig_expire[i])
                begin
                    online_r[i] <= 1'b0;
                end
                else if (sec_tick && online_r[i])
                begin
                    ttl_r[i] <= ttl_r[i] - 16'h0001;
                end
            end
        end
    end

    // Timers and transmit message
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sec_cnt_r  <= 32'h0;
            elapsed_r  <= 6'h0;
            powerup_r  <= 1'b1;
            snap_r     <= '0;
            tx_valid_r <= 1'b0;
            tx_dna_r   <= 64'h0;
            tx_user_r  <= 64'h0;
            dir_out_r  <= 32'h0;
        end
        else
        begin
            sec_cnt_r  <= sec_tick ? 32'h0 : sec_cnt_r + 32'h1;
            tx_valid_r <= send;
            dir_out_r  <= pt_dout;
            if (send)
            begin
                powerup_r <= 1'b0;
                elapsed_r <= 6'h0;
                snap_r    <= pt_all;
                tx_dna_r  <= dna_pairs;
                tx_user_r <= user_pairs;
            end
            else if (sec_tick)
            begin
                elapsed_r <= 6'(elapsed_r + 6'h01);
            end
        end
    end

    // Reset sources, latches, count
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            logic_sig_d_r <= 1'b0;
            rst_btn_r     <= 1'b0;
            rst_link_r    <= 1'b0;
            rst_logic_r   <= 1'b0;
            latched_r     <= '0;
            rst_count_r   <= 16'h0;
        end
        else
        begin
            logic_sig_d_r <= logic_sig;
            rst_btn_r     <= front_button_req;
            rst_link_r    <= link_reset_req;
            rst_logic_r   <= logic_rise;
            latched_r     <= latch_cond | (latched_r & ~{`RPIM_N_LATCH{any_rst}});
            if (any_rst)
            begin
                rst_count_r <= rst_count_r + 16'h1;
            end
        end
    end

    // Read mux
    logic [31:0] rd_mux;
    assign rd_mux = (reg_addr == `RPIM_A_CTRL)      ? ctrl_r :
                    (reg_addr == `RPIM_A_STATUS)    ? 32'(status_r) :
                    (reg_addr == `RPIM_A_MASK)      ? 32'(mask_r) :
                    (reg_addr == `RPIM_A_ONLINE)    ? 32'(online_r) :
                    (reg_addr == `RPIM_A_REMIN_VAL) ? remote_in_r :
                    (reg_addr == `RPIM_A_DIRIN_VAL) ? direct_in_r :
                    (reg_addr == `RPIM_A_LATCHED)   ? 32'(latched_r) :
                    (reg_addr == `RPIM_A_RST_COUNT) ? 32'(rst_count_r) :
                    hit_oid  ? orig_id_mem[ent[3:0]] :
                    hit_omat ? orig_mat_mem[ent[3:0]] :
                    hit_rin  ? 32'(remin_cfg[ent]) :
                    hit_din  ? 32'(dirin_cfg[ent]) :
                    hit_dna  ? 32'(dna_sel[ent]) :
                    hit_usr  ? 32'(user_sel[ent]) :
                    hit_dout ? 32'(dout_sel[ent]) : 32'h0;

    // Status, read data, point outputs
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            status_r    <= '0;
            rdata_r     <= 32'h0;
            remote_in_r <= '0;
            direct_in_r <= '0;
        end
        else
        begin
            status_r    <= status_nxt;
            rdata_r     <= reg_rd ? rd_mux : 32'h0;
            remote_in_r <= rin_now;
            direct_in_r <= din_now;
        end
    end

    // Output drive
    assign reg_rdata               = rdata_r;
    assign tx_valid                = tx_valid_r;
    assign tx_goose                = (fmt == FMT_GOOSE);
    assign tx_dna                  = tx_dna_r;
    assign tx_userst               = tx_user_r;
    assign dir_out                 = dir_out_r;
    assign remote_in               = remote_in_r;
    assign direct_in               = direct_in_r;
    assign latched_flags           = latched_r;
    assign reset_from_front_button = rst_btn_r;
    assign reset_from_link         = rst_link_r;
    assign reset_from_logic_signal = rst_logic_r;
    assign any_source_reset_pulse  = rst_btn_r | rst_link_r | rst_logic_r;
    assign irq                     = |(status_r & mask_r);

endmodule

`default_nettype wire

// ==== verilog/rpim_cfg.svh ====
/*
 * Register map, fields, reset values and timing of the point mapper.
 * Assumes it is included by its bare name and only once per compilation unit.
 */
`ifndef RPIM_CFG_SVH
`define RPIM_CFG_SVH

// Clock and timing figures
`define RPIM_CLK_PERIOD_NS   100
`define RPIM_SEC_MS          1000
`define RPIM_NS_PER_MS       1000000

// Sizes
`define RPIM_N_ORIG          16
`define RPIM_N_POINT         32
`define RPIM_N_LATCH         8

// Single registers (word addresses)
`define RPIM_A_CTRL          8'h00
`define RPIM_A_STATUS        8'h01
`define RPIM_A_MASK          8'h02
`define RPIM_A_ONLINE        8'h03
`define RPIM_A_REMIN_VAL     8'h04
`define RPIM_A_DIRIN_VAL     8'h05
`define RPIM_A_LATCHED       8'h06
`define RPIM_A_RST_COUNT     8'h07

// Tables: high bits pick the table, low bits the entry
`define RPIM_PFX_ORIG_ID     4'h2
`define RPIM_PFX_ORIG_MATCH  4'h3
`define RPIM_PFX_REMIN       3'h2
`define RPIM_PFX_DIRIN       3'h3
`define RPIM_PFX_DNA_SEL     3'h4
`define RPIM_PFX_USER_SEL    3'h5
`define RPIM_PFX_DOUT_SEL    3'h6

// Control register fields
`define RPIM_CTRL_FMT_LSB    0
`define RPIM_CTRL_INT_LSB    8
`define RPIM_CTRL_RSEL_LSB   16
`define RPIM_INTERVAL_RST    6'h3C
`define RPIM_INTERVAL_MIN    6'h01

// Originator match entry fields
`define RPIM_OM_APPID_LSB    0
`define RPIM_OM_VLAN_LSB     16
`define RPIM_OM_VALID_BIT    31

// Input config fields
`define RPIM_CFG_DEV_LSB     0
`define RPIM_CFG_SEL_LSB     4
`define RPIM_CFG_DEF_LSB     12

// Status bits
`define RPIM_ST_RX_ACCEPT    0
`define RPIM_ST_ORIG_LOST    1
`define RPIM_ST_RESET        2
`define RPIM_ST_TX_SENT      3
`define RPIM_ST_W            4

// Fixed transmit points
`define RPIM_DNA_TEST        0
`define RPIM_DNA_CONFREV     1

`endif

// ==== verilog/rpim_pkg.sv ====
/*
 * Types of the point mapper.
 * Assumes rpim_cfg.svh holds the numbers.
 */
`default_nettype none

package rpim_pkg;

    // Transport format choice
    typedef enum logic [1:0] {
        FMT_GOOSE = 2'h0,
        FMT_GSSE  = 2'h1,
        FMT_NONE  = 2'h2
    } fmt_t;

    // Default state behaviour of a received point
    typedef enum logic [1:0] {
        DEF_OFF        = 2'h0,
        DEF_ON         = 2'h1,
        DEF_LATEST_OFF = 2'h2,
        DEF_LATEST_ON  = 2'h3
    } def_t;

endpackage

`default_nettype wire

// ==== testbench/rpim_monitor.sv ====
/* Checker on the mapper's reset, latch and send ports.
   Assumes it is bound into remote_point_input_mapper. */
`default_nettype none
module rpim_monitor
#(
    parameter int unsigned SEC_CYCLES = 20
)
(
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic       tx_valid,
    input wire logic       front_button_req,
    input wire logic       link_reset_req,
    input wire logic [7:0] latch_cond,
    input wire logic [7:0] latched_flags,
    input wire logic       any_source_reset_pulse,
    input wire logic       reset_from_front_button,
    input wire logic       reset_from_link,
    input wire logic       reset_from_logic_signal
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] gap_r;
    // Cycles since last send
    always_ff @(posedge ref_clk)
        gap_r <= (sys_rst || tx_valid) ? 32'h0 : gap_r + 32'h1;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_button_reset: assert property (front_button_req |=> reset_from_front_button)
        else $error("button reset missing");
    a_link_reset: assert property (link_reset_req ##1 !link_reset_req |-> reset_from_link ##1 !reset_from_link)
        else $error("link reset not one pulse");
    a_common_reset: assert property ((reset_from_front_button || reset_from_link || reset_from_logic_signal)
        |-> any_source_reset_pulse)
        else $error("common reset missing");
    a_common_cause: assert property (any_source_reset_pulse
        |-> (reset_from_front_button || reset_from_link || reset_from_logic_signal))
        else $error("common reset without source");
    a_latch_set: assert property (|latch_cond |=> (latched_flags & $past(latch_cond)) == $past(latch_cond))
        else $error("flag not latched");
    a_latch_keep: assert property (1'b1 |=> any_source_reset_pulse
        || (latched_flags & $past(latched_flags)) == $past(latched_flags))
        else $error("flag lost without reset");
    a_reset_clear: assert property (any_source_reset_pulse |-> latched_flags == $past(latch_cond))
        else $error("reset cleared wrong flags");
    a_startup_send: assert property ($fell(sys_rst) |-> ##[1:2] tx_valid)
        else $error("no send at startup");
    a_resend_bound: assert property (gap_r <= 61 * SEC_CYCLES)
        else $error("resend interval overrun");
endmodule
bind remote_point_input_mapper rpim_monitor #(.SEC_CYCLES(SEC_CYCLES)) u_mon (.ref_clk, .sys_rst, .tx_valid,
    .front_button_req, .link_reset_req, .latch_cond, .latched_flags, .any_source_reset_pulse,
    .reset_from_front_button, .reset_from_link, .reset_from_logic_signal);
`default_nettype wire

// ==== testbench/peer_device.sv ====
/* Peer device that sends one state message on request.
   Assumes calls start from bench code running at clock edges. */
`default_nettype none
module peer_device
(
    input  wire logic        ref_clk,
    output logic             rx_valid,
    output logic             rx_goose,
    output logic      [31:0] rx_orig_id,
    output logic      [11:0] rx_vlan,
    output logic      [15:0] rx_appid,
    output logic      [15:0] rx_ttl_s,
    output logic      [63:0] rx_dna,
    output logic      [63:0] rx_userst
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
        {rx_valid, rx_goose, rx_orig_id, rx_vlan, rx_appid, rx_ttl_s, rx_dna, rx_userst} = '0;
    // One frame, then fields go stale
    task automatic send(input logic g, input logic [31:0] id, input logic [11:0] vl,
                        input logic [63:0] dna, input logic [63:0] us, input logic [15:0] ttl);
        @(posedge ref_clk);
        {rx_goose, rx_orig_id, rx_vlan, rx_appid, rx_ttl_s} <= {g, id, vl, 4'h0, vl, ttl};
        {rx_dna, rx_userst} <= {dna, us};
        rx_valid <= 1'b1;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        {rx_orig_id, rx_dna, rx_userst} <= ~{rx_orig_id, rx_dna, rx_userst};
    endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
/* Self-checking bench of the point mapper.
   Assumes the peer model and the checker are compiled alongside. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned SEC = 20;
    logic        ref_clk, sys_rst, reg_wr, reg_rd, rx_valid, rx_goose, dir_valid, test_mode, conf_rev, tx_valid;
    logic        tx_goose, front_button_req, link_reset_req, any_source_reset_pulse, reset_from_front_button;
    logic        reset_from_link, reset_from_logic_signal, irq;
    logic [3:0]  dir_dev_id;
    logic [7:0]  reg_addr, latch_cond, latched_flags;
    logic [11:0] rx_vlan;
    logic [15:0] rx_appid, rx_ttl_s, dir_dev_online;
    logic [31:0] reg_wdata, reg_rdata, rx_orig_id, dir_bits, dir_out, remote_in, direct_in, rv;
    logic [63:0] rx_dna, rx_userst, int_sig, tx_dna, tx_userst;
    int          fails = 0, n_checks = 0, cyc = 0, n;
    remote_point_input_mapper #(.SEC_CYCLES(SEC)) u_dut (.*);
    peer_device u_peer (.*);
    task automatic stop_test;
        if (fails == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One register cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge ref_clk);
        {reg_wr, reg_rd} <= 2'b00;
        @(negedge ref_clk);
        rv = reg_rdata;
    endtask
    task automatic look(input int c);
        repeat (c) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic wait_tx;
        n = 0;
        do @(posedge ref_clk); while (tx_valid !== 1'b1 && ++n < 200);
        @(negedge ref_clk);
    endtask
    // Clock and hang guard
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        if (++cyc == 6000)
        begin
            fails++;
            stop_test();
        end
    initial
    begin
        sys_rst = 1'b1;
        {reg_wr, reg_rd, dir_valid, test_mode, conf_rev, front_button_req, link_reset_req} = '0;
        {reg_addr, reg_wdata, dir_bits, dir_dev_id, dir_dev_online, int_sig, latch_cond} = '0;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        bus(1'b1, 8'h21, 32'h0000_00A5);
        bus(1'b1, 8'h31, 32'h8000_0000);
        bus(1'b1, 8'h40, 32'h0000_1031);
        bus(1'b1, 8'h41, 32'h0000_2251);
        look(2);
        chk(remote_in[1:0], 2'b01, "startup");
        u_peer.send(1'b0, 32'h0000_00A6, 12'h0, 64'h0, 64'h0, 16'h2);
        look(3);
        chk(remote_in[1:0], 2'b01, "foreign");
        u_peer.send(1'b0, 32'h0000_00A5, 12'h5, 64'h40, 64'h800, 16'h2);
        look(3);
        chk(remote_in[1:0], 2'b10, "gsse");
        bus(1'b1, 8'h00, 32'h0000_0200);
        chk(tx_goose, 1'b1, "format");
        u_peer.send(1'b1, 32'h0000_00A5, 12'h5, 64'h80, 64'h0, 16'h2);
        look(3);
        chk(remote_in[1:0], 2'b10, "vlan");
        u_peer.send(1'b1, 32'h0000_00A5, 12'h0, 64'h40, 64'h800, 16'h2);
        look(2 * SEC + 4);
        chk(remote_in[1:0], 2'b11, "expiry");
        u_peer.send(1'b1, 32'h0000_00A5, 12'h0, 64'h40, 64'h0, 16'h2);
        look(3);
        chk(remote_in[1:0], 2'b00, "resume");
        dir_dev_online <= 16'h0008;
        bus(1'b1, 8'h60, 32'h0000_30B3);
        bus(1'b1, 8'h61, 32'h0000_1005);
        @(posedge ref_clk);
        {dir_dev_id, dir_bits, dir_valid} <= {4'h3, 32'hFFFF_F7FF, 1'b1};
        @(posedge ref_clk);
        {dir_bits, dir_valid} <= {32'h0000_0800, 1'b0};
        look(3);
        chk(direct_in[1:0], 2'b10, "direct bit");
        @(posedge ref_clk);
        dir_dev_online <= 16'h0000;
        look(3);
        chk(direct_in[1:0], 2'b10, "direct hold");
        bus(1'b1, 8'h82, 32'h0000_0007);
        bus(1'b1, 8'hA0, 32'h0000_0009);
        bus(1'b1, 8'hC0, 32'h0000_0009);
        {int_sig, test_mode} <= {64'h280, 1'b1};
        wait_tx;
        chk({tx_dna[5:0], tx_userst[1:0], dir_out[0]}, 9'b100110_10_1, "tx points");
        wait_tx;
        chk(n > SEC && n <= 2 * SEC + 2, 1'b1, "interval");
        bus(1'b1, 8'h00, 32'h0014_0202);
        wait_tx;
        chk({n, tx_goose}, {32'd200, 1'b0}, "no transport");
        bus(1'b1, 8'h00, 32'h0014_0201);
        latch_cond <= 8'h03;
        @(posedge ref_clk);
        {latch_cond, front_button_req} <= {8'h01, 1'b1};
        @(posedge ref_clk);
        {latch_cond, front_button_req} <= {8'h00, 1'b0};
        look(0);
        chk({latched_flags, any_source_reset_pulse, reset_from_front_button}, 10'h007, "button");
        look(2);
        chk(latched_flags, 8'h01, "latched");
        link_reset_req <= 1'b1;
        @(posedge ref_clk);
        link_reset_req <= 1'b0;
        look(0);
        chk({latched_flags, reset_from_link}, 9'h001, "link");
        @(posedge ref_clk);
        int_sig <= 64'h0010_0280;
        look(1);
        chk({any_source_reset_pulse, reset_from_logic_signal}, 2'b11, "logic");
        bus(1'b0, 8'h07, 32'h0);
        chk(rv, 32'h3, "count");
        bus(1'b1, 8'h02, 32'h4);
        look(1);
        chk(irq, 1'b1, "irq");
        bus(1'b0, 8'h01, 32'h0);
        look(1);
        chk({rv[2], irq}, 2'b10, "status");
        bus(1'b0, 8'h10, 32'h0);
        chk(rv, 32'h0, "unmapped");
        stop_test();
    end
endmodule
`default_nettype wire
